// file: fps_pkg.sv
// constants and types for the single-precision product summer
package fps_pkg;
    localparam logic [11:0] FPS_CTRL_OFF = 12'h000;
    localparam logic [11:0] FPS_RESULT_OFF = 12'h004;
    localparam logic [11:0] FPS_STATUS_OFF = 12'h008;
    localparam int FPS_FUNC_BIT = 0;
    localparam int FPS_MODE_LSB = 1;
    localparam int FPS_MODE_MSB = 2;
    localparam logic [2:0] FPS_CTRL_RST = 3'h0;
    localparam int FPS_LATENCY = 4;
    localparam int FPS_FIFO_DEPTH = 8;
    localparam int FPS_WIDTH = 32;
    localparam logic [31:0] FPS_ONE = 32'h3f800000;
    localparam logic [31:0] FPS_QNAN = 32'h7fc00000;
    localparam logic [31:0] FPS_ZERO = 32'h00000000;
    localparam logic [7:0] FPS_EXP_MAX = 8'hff;
    localparam logic signed [9:0] FPS_BIAS = 10'h07f;

    typedef enum logic {FPS_FN_PRODUCT_SUM, FPS_FN_SUM_ONLY} fps_func_t;
    typedef enum logic [1:0] {FPS_MODE_INHERIT, FPS_MODE_SPECIFY, FPS_MODE_BOOL} fps_mode_t;

    typedef struct packed {
        logic valid;
        logic keep;
        fps_func_t func;
        logic [31:0] x;
        logic [31:0] y;
    } fps_opnd_t;

    typedef struct packed {
        logic valid;
        logic keep;
        fps_func_t func;
        logic sign;
        logic special;
        logic zero;
        logic signed [9:0] exp;
        logic [47:0] mant;
    } fps_prod_t;

    typedef struct packed {
        logic valid;
        logic keep;
        fps_func_t func;
        logic [31:0] val;
    } fps_word_t;
endpackage

// file: fps_product_summer.sv
// single-precision product summer with result fifo and apb control
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module fps_fifo import fps_pkg::*; #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = count != DEPTH[$clog2(DEPTH+1)-1:0];
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + {{($clog2(DEPTH+1)-1){1'b0}}, push} - {{($clog2(DEPTH+1)-1){1'b0}}, pop};
        end
    end

    fifo_no_overrun_a: assert property (@(posedge pclk) disable iff (!presetn)
        in_valid |-> in_ready)
        else $error("word offered to a full fifo");
endmodule

module fps_product_summer import fps_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [31:0] x,
    input wire logic [31:0] y,
    input wire logic keep_sum,
    output logic [31:0] q,
    output logic q_bool,
    output logic q_valid,
    output logic res_valid,
    input wire logic res_ready,
    output logic [31:0] res_data
);
    logic [2:0] ctrl;
    logic [31:0] acc;
    fps_opnd_t s1;
    fps_prod_t s2;
    fps_word_t s3;
    logic [3:0] fifo_count;

    // flush denormals to a signed zero
    function automatic logic [31:0] ftz(input logic [31:0] v);
        ftz = (v[30:23] == 8'h00) ? {v[31], 31'h00000000} : v;
    endfunction

    // normalise the raw mantissa product, truncating extra bits
    function automatic logic [31:0] pack_prod(input fps_prod_t p);
        logic signed [9:0] e;
        logic [22:0] m;
        e = p.exp + (p.mant[47] ? 10'sh001 : 10'sh000);
        m = p.mant[47] ? p.mant[46:24] : p.mant[45:23];
        if (p.special) begin
            pack_prod = FPS_QNAN;
        end else if (p.zero || e <= 10'sh000) begin
            pack_prod = {p.sign, 31'h00000000};
        end else if (e >= 10'sh0ff) begin
            pack_prod = {p.sign, FPS_EXP_MAX, 23'h000000};
        end else begin
            pack_prod = {p.sign, e[7:0], m};
        end
    endfunction

    // aligned add with truncation; small results flush to zero
    function automatic logic [31:0] fp_add(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] big;
        logic [31:0] sml;
        logic [7:0] d;
        logic [26:0] mb;
        logic [26:0] ms;
        logic [26:0] s;
        logic [8:0] e;
        big = (a[30:0] >= b[30:0]) ? a : b;
        sml = (a[30:0] >= b[30:0]) ? b : a;
        d = big[30:23] - sml[30:23];
        mb = {2'b01, big[22:0], 2'b00};
        ms = (d > 8'd26) ? 27'h0 : ({2'b01, sml[22:0], 2'b00} >> d);
        s = (big[31] == sml[31]) ? mb + ms : mb - ms;
        e = {1'b0, big[30:23]};
        if (s[26]) begin
            s = s >> 1;
            e = e + 9'h001;
        end
        for (int i = 0; i < 26; i++) begin
            if (!s[25] && e != 9'h000) begin
                s = s << 1;
                e = e - 9'h001;
            end
        end
        if (big[30:23] == FPS_EXP_MAX || sml[30:23] == 8'h00) begin
            fp_add = big;
        end else if (!s[25] || e == 9'h000) begin
            fp_add = {big[31], 31'h00000000};
        end else if (e >= 9'h0ff) begin
            fp_add = {big[31], FPS_EXP_MAX, 23'h000000};
        end else begin
            fp_add = {big[31], e[7:0], s[24:2]};
        end
    endfunction

    // apb decode, zero wait states
    wire apb_setup = psel && !penable;
    wire apb_access = psel && penable;
    wire hit_ctrl = paddr == FPS_CTRL_OFF;
    wire hit_result = paddr == FPS_RESULT_OFF;
    wire hit_status = paddr == FPS_STATUS_OFF;
    wire hit_any = hit_ctrl || hit_result || hit_status;
    wire ctrl_wr = apb_access && pwrite && hit_ctrl;
    wire fps_func_t func = fps_func_t'(ctrl[FPS_FUNC_BIT]);
    wire fps_mode_t mode = fps_mode_t'(ctrl[FPS_MODE_MSB:FPS_MODE_LSB]);
    logic [31:0] rd_mux;

    assign pready = 1'b1;
    assign pslverr = apb_access && !hit_any;
    assign rd_mux = hit_ctrl ? {29'h0, ctrl}
                  : hit_result ? acc
                  : hit_status ? {28'h0, fifo_count}
                  : FPS_ZERO;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= FPS_CTRL_RST;
            prdata <= FPS_ZERO;
        end else begin
            if (ctrl_wr) begin
                ctrl <= pwdata[2:0];
            end
            if (apb_setup && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // admission: room for every word already in flight
    wire [4:0] in_flight = 5'(s1.valid) + 5'(s2.valid) + 5'(s3.valid) + 5'(q_valid);
    assign in_ready = (5'(fifo_count) + in_flight) < 5'(FPS_FIFO_DEPTH);
    wire in_fire = in_valid && in_ready;

    // stage 1: capture and flush operands
    fps_opnd_t next_s1;
    assign next_s1.valid = in_fire;
    assign next_s1.keep = keep_sum;
    assign next_s1.func = func;
    assign next_s1.x = ftz(x);
    assign next_s1.y = (func == FPS_FN_SUM_ONLY) ? FPS_ONE : ftz(y);

    // stage 2: multiply mantissas
    fps_prod_t next_s2;
    assign next_s2.valid = s1.valid;
    assign next_s2.keep = s1.keep;
    assign next_s2.func = s1.func;
    assign next_s2.sign = s1.x[31] ^ s1.y[31];
    assign next_s2.special = s1.x[30:23] == FPS_EXP_MAX || s1.y[30:23] == FPS_EXP_MAX;
    assign next_s2.zero = s1.x[30:23] == 8'h00 || s1.y[30:23] == 8'h00;
    assign next_s2.exp = $signed({2'b00, s1.x[30:23]}) + $signed({2'b00, s1.y[30:23]}) - FPS_BIAS;
    assign next_s2.mant = {1'b1, s1.x[22:0]} * {1'b1, s1.y[22:0]};

    // stage 3: product as a float
    fps_word_t next_s3;
    assign next_s3.valid = s2.valid;
    assign next_s3.keep = s2.keep;
    assign next_s3.func = s2.func;
    assign next_s3.val = pack_prod(s2);

    // stage 4: sum with the previous result or with zero
    wire [31:0] addend = s3.keep ? acc : FPS_ZERO;
    wire [31:0] next_acc = fp_add(addend, s3.val);
    wire [31:0] next_q = (mode == FPS_MODE_BOOL) ? {31'h0, next_acc[0]} : next_acc;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= next_s1;
            s2 <= next_s2;
            s3 <= next_s3;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= FPS_ZERO;
            q <= FPS_ZERO;
            q_bool <= 1'b0;
            q_valid <= 1'b0;
        end else begin
            q_valid <= s3.valid;
            if (s3.valid) begin
                acc <= next_acc;
                q <= next_q;
                q_bool <= (mode == FPS_MODE_BOOL) && next_acc[0];
            end
        end
    end

    fps_fifo #(
        .WIDTH(FPS_WIDTH),
        .DEPTH(FPS_FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(q_valid),
        .in_ready(),
        .in_data(q),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(res_data),
        .count(fifo_count)
    );

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    result_latency_a: assert property (q_valid == $past(in_fire, 4))
        else $error("result not exactly four cycles after operands");

    format_const_a: assert property (in_fire ##4 q_valid |->
        mode != FPS_MODE_BOOL || q[31:1] == 31'h0)
        else $error("boolean mode result carries upper bits");

    keep_product_a: assert property (in_fire && func == FPS_FN_PRODUCT_SUM && keep_sum
        && x[30:23] == 8'h00 && y[30:23] != FPS_EXP_MAX |-> ##4 $stable(acc))
        else $error("adding a zero product changed the running result");

    discard_product_a: assert property (in_fire && func == FPS_FN_PRODUCT_SUM && !keep_sum
        && x[30:23] == 8'h00 && y[30:23] != FPS_EXP_MAX |-> ##4 acc[30:0] == 31'h0)
        else $error("discarded sum leaked into a zero product");

    keep_sum_only_a: assert property (in_fire && func == FPS_FN_SUM_ONLY && keep_sum
        && x[30:23] == 8'h00 |-> ##4 $stable(acc))
        else $error("adding zero changed the running sum");

    pass_through_a: assert property (in_fire && func == FPS_FN_SUM_ONLY && !keep_sum
        && x[30:23] != 8'h00 && x[30:23] != FPS_EXP_MAX |-> ##4 acc == $past(x, 4))
        else $error("sum-only pass through altered x");

    input_flush_a: assert property (in_fire && !keep_sum && x[30:23] == 8'h00
        && (func == FPS_FN_SUM_ONLY || y[30:23] != FPS_EXP_MAX) |-> ##4 acc[30:0] == 31'h0)
        else $error("denormal input not flushed");

    output_flush_a: assert property (q_valid |-> acc[30:23] != 8'h00 || acc[22:0] == 23'h0)
        else $error("denormal result not flushed");

    y_forced_a: assert property (in_fire && func == FPS_FN_SUM_ONLY |=> s1.y == FPS_ONE)
        else $error("y not held at one in sum-only function");

    raw_bits_a: assert property (q_valid && $past(mode) != FPS_MODE_BOOL |-> q == acc)
        else $error("output bits differ from the raw result");

    bool_out_a: assert property (q_valid && $past(mode) == FPS_MODE_BOOL
        |-> q_bool == acc[0] && q[31:1] == 31'h0)
        else $error("boolean output wrong");

    reset_zero_a: assert property ($rose(presetn) |-> acc == FPS_ZERO)
        else $error("previous result not zero after reset");

    back_pressure_a: assert property (5'(fifo_count) + in_flight <= 5'(FPS_FIFO_DEPTH))
        else $error("more words admitted than the result fifo can hold");

    ctrl_write_a: assert property (ctrl_wr |=> ctrl == $past(pwdata[2:0]))
        else $error("control write did not land");

    prdata_ctrl_a: assert property (apb_setup && !pwrite && hit_ctrl
        |=> prdata == {29'h0, $past(ctrl)})
        else $error("control read data wrong");

    status_read_a: assert property (apb_setup && !pwrite && hit_status
        |=> prdata == {28'h0, $past(fifo_count)})
        else $error("status read data wrong");

    unmapped_err_a: assert property (apb_access && !pwrite && !hit_any
        |-> pslverr && prdata == FPS_ZERO)
        else $error("unmapped read not refused");

    q_hold_a: assert property (!s3.valid |=> $stable(q) && $stable(acc))
        else $error("result changed without a new sample");

    bool_low_a: assert property (q_valid && $past(mode) != FPS_MODE_BOOL |-> !q_bool)
        else $error("boolean output set outside boolean mode");

    fifo_hold_a: assert property (res_valid && !res_ready
        |=> res_valid && $stable(res_data))
        else $error("stalled result word not held");

    reset_outputs_a: assert property ($rose(presetn)
        |-> !q_valid && q == FPS_ZERO && !res_valid)
        else $error("outputs not idle after reset");

    cover_chain_c: cover property (in_fire && keep_sum ##1 in_fire && keep_sum ##1 in_fire);
    cover_sum_only_c: cover property (in_fire && func == FPS_FN_SUM_ONLY ##4 q_valid);
    cover_fifo_full_c: cover property (fifo_count == 4'(FPS_FIFO_DEPTH) ##1 res_ready);
    cover_bool_c: cover property (q_valid && q_bool);
endmodule

// file: fps_sink.sv
// downstream consumer model for the result stream
`timescale 1ns/1ps

module fps_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    input wire logic res_valid,
    input wire logic [31:0] res_data,
    output logic res_ready
);
    logic [31:0] got[$];

    assign res_ready = !stall;

    always @(posedge pclk) begin
        if (presetn && res_valid && res_ready) begin
            got.push_back(res_data);
        end
    end
endmodule

// file: fps_product_summer_tb.sv
// self-checking bench for the product summer
`timescale 1ns/1ps

module fps_product_summer_tb import fps_pkg::*;;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] x = 32'h0;
    logic [31:0] y = 32'h0;
    logic in_valid = 1'b0;
    logic keep_sum = 1'b0;
    logic stall = 1'b0;
    logic [31:0] prdata, q, res_data;
    logic pready, pslverr, in_ready, q_bool, q_valid, res_valid, res_ready, rdy;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;

    fps_product_summer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .x(x), .y(y),
        .keep_sum(keep_sum), .q(q), .q_bool(q_bool), .q_valid(q_valid),
        .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));

    fps_sink dn (.pclk(pclk), .presetn(presetn), .stall(stall), .res_valid(res_valid),
        .res_data(res_data), .res_ready(res_ready));

    always #5 pclk = ~pclk;

    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic s;
        apb(1'b1, a, d, r, s);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic es);
        logic [31:0] r;
        logic s;
        apb(1'b0, a, 32'h0, r, s);
        chk("prdata", e, r);
        chk("pslverr", {31'h0, es}, {31'h0, s});
    endtask

    // one sample; q_valid rises at the third edge after the edge that takes it
    task automatic send(input logic [31:0] xv, input logic [31:0] yv, input logic k,
        input logic [31:0] e, input logic eb);
        @(posedge pclk);
        in_valid <= 1'b1;
        x <= xv;
        y <= yv;
        keep_sum <= k;
        @(posedge pclk);
        in_valid <= 1'b0;
        repeat (2) @(posedge pclk);
        #1 chk("q_valid early", 32'h0, {31'h0, q_valid});
        @(posedge pclk);
        #1 chk("q_valid", 32'h1, {31'h0, q_valid});
        chk("q", e, q);
        chk("q_bool", {31'h0, eb}, {31'h0, q_bool});
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(FPS_CTRL_OFF, 32'h0, 1'b0);
        rdchk(FPS_RESULT_OFF, 32'h0, 1'b0);
        rdchk(12'h00c, 32'h0, 1'b1);
        send(32'h40000000, 32'h40400000, 1'b1, 32'h40c00000, 1'b0);
        send(32'h3f800000, 32'h3f000000, 1'b1, 32'h40d00000, 1'b0);
        send(32'h3fc00000, 32'h40000000, 1'b0, 32'h40400000, 1'b0);
        send(32'h00400000, 32'h40000000, 1'b1, 32'h40400000, 1'b0);
        send(32'h00400000, 32'h40000000, 1'b0, 32'h0, 1'b0);
        send(32'h1c800000, 32'h1c800000, 1'b0, 32'h0, 1'b0);
        rdchk(FPS_RESULT_OFF, 32'h0, 1'b0);
        wr(FPS_CTRL_OFF, 32'h1);
        rdchk(FPS_CTRL_OFF, 32'h1, 1'b0);
        send(32'h3fc00000, 32'h40a00000, 1'b0, 32'h3fc00000, 1'b0);
        send(32'h40200000, 32'h40a00000, 1'b1, 32'h40800000, 1'b0);
        send(32'h00000001, 32'h40a00000, 1'b1, 32'h40800000, 1'b0);
        wr(FPS_CTRL_OFF, 32'h5);
        send(32'h3f800001, 32'h0, 1'b0, 32'h1, 1'b1);
        wr(FPS_CTRL_OFF, 32'h3);
        send(32'h3f800001, 32'h0, 1'b0, 32'h3f800001, 1'b0);
        wr(FPS_CTRL_OFF, 32'h7);
        send(32'h3f800001, 32'h0, 1'b0, 32'h3f800001, 1'b0);
        wr(FPS_CTRL_OFF, 32'h1);
        send(32'hbf800001, 32'h0, 1'b0, 32'hbf800001, 1'b0);
        // back-to-back stream into a stalled result buffer
        repeat (4) @(posedge pclk);
        stall <= 1'b1;
        dn.got.delete();
        n = 0;
        in_valid <= 1'b1;
        keep_sum <= 1'b0;
        x <= 32'h3f800000;
        repeat (14) begin
            #1 rdy = in_ready;
            @(posedge pclk);
            if (rdy === 1'b1) n++;
            x <= 32'h3f800000 + n;
        end
        in_valid <= 1'b0;
        repeat (6) @(posedge pclk);
        #1 chk("taken", 32'h8, 32'(n));
        chk("in_ready", 32'h0, {31'h0, in_ready});
        rdchk(FPS_STATUS_OFF, 32'h8, 1'b0);
        stall <= 1'b0;
        repeat (12) @(posedge pclk);
        #1 chk("drained", 32'h8, 32'(dn.got.size()));
        for (int i = 0; i < dn.got.size(); i++) begin
            chk("stream word", 32'h3f800000 + i, dn.got[i]);
        end
        chk("res_valid", 32'h0, {31'h0, res_valid});
        final_report();
    end
endmodule
